// file: pic_ops_defines.svh
`ifndef PIC_OPS_DEFINES_SVH
`define PIC_OPS_DEFINES_SVH
`define CMD_KIND_BIT 4
`define CMD_MODE_BIT 3
`define MODE_UNLOCK_BIT 6
`define MODE_SPECIAL_BIT 5
`define MODE_QUERY_BIT 2
`define MODE_READ_BIT 1
`define MODE_SERVICE_SEL_BIT 0
`define PRIO_ROTATE_BIT 7
`define PRIO_LEVEL_SEL_BIT 6
`define PRIO_DONE_BIT 5
`define POLL_VALID_BIT 7
`define MASK_RESET 8'h00
`define LOWEST_RESET 3'h7
`define ACK_LAST_8BIT 2'h2
`define ACK_LAST_16BIT 2'h1
`endif

// file: pic_ops_pkg.sv
package pic_ops_pkg;
   typedef struct packed {
      logic [7:0] data;
      logic addr;
      logic rd;
      logic wr;
   } bus_req_s;
   typedef enum logic [1:0] {
      sel_request,
      sel_service
   } read_sel_e;
endpackage : pic_ops_pkg

// file: pic_ops_resolver.sv
// finds the highest-priority set bit of a vector under rotated priority
module pic_ops_resolver #(
   parameter int WIDTH = 8
) (
   input wire logic [WIDTH-1:0] vec_in,
   input wire logic [2:0] lowest_in,
   output logic found_out,
   output logic [2:0] level_out
);
   initial begin
      if (WIDTH != 8) $error("resolver serves eight levels only");
   end
   always_comb begin
      logic [2:0] idx;
      idx = 3'h0;
      found_out = 1'b0;
      level_out = 3'h0;
      for (int i = 0; i < WIDTH; i++) begin
         // walk from lowest to highest priority so the last hit is the best
         idx = 3'(lowest_in - 3'(i));
         if (vec_in[idx]) begin
            found_out = 1'b1;
            level_out = idx;
         end
      end
   end
endmodule : pic_ops_resolver

// file: pic_ops_sync.sv
// three-stage synchroniser; a change counts once stages two and three agree
module pic_ops_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   initial begin
      if (WIDTH < 1) $error("width must be positive");
   end
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         sync_out <= '0;
      end else begin
         s1_reg <= async_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_reg[i] == s3_reg[i]) sync_out[i] <= s3_reg[i];
         end
      end
   end
endmodule : pic_ops_sync

// file: pic_ops_top.sv
`include "pic_ops_defines.svh"
module pic_ops_top (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic chip_select_n_in,
   input wire logic read_n_in,
   input wire logic write_n_in,
   input wire logic addr_in,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe_out,
   input wire logic [7:0] request_inputs_in,
   input wire logic acknowledge_strobe_n_in,
   input wire logic auto_service_done_in,
   input wire logic cpu16_mode_in,
   output logic interrupt_out,
   output logic special_mask_out
);
   // strobe and pin synchronisation
   logic [3:0] pins_sync;
   logic [7:0] req_sync;
   logic cs_s;
   logic rd_s;
   logic wr_s;
   logic ack_s;
   pic_ops_sync #(.WIDTH(4)) u_strobe_sync (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .async_in({~chip_select_n_in, ~read_n_in, ~write_n_in, ~acknowledge_strobe_n_in}),
      .sync_out(pins_sync)
   );
   pic_ops_sync #(.WIDTH(8)) u_req_sync (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .async_in(request_inputs_in),
      .sync_out(req_sync)
   );
   assign cs_s = pins_sync[3];
   assign rd_s = pins_sync[2];
   assign wr_s = pins_sync[1];
   assign ack_s = pins_sync[0];
   // data and address pass the same synchroniser depth as the strobes, so the
   // last synced write cycle still sees the data that stood at the pin's rise
   logic [8:0] data_sync;
   logic [7:0] data_reg;
   logic addr_reg;
   pic_ops_sync #(.WIDTH(9)) u_data_sync (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .async_in({addr_in, data_in}),
      .sync_out(data_sync)
   );
   assign data_reg = data_sync[7:0];
   assign addr_reg = data_sync[8];
   logic rd_d_reg;
   logic wr_d_reg;
   logic ack_d_reg;
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         rd_d_reg <= 1'b0;
         wr_d_reg <= 1'b0;
         ack_d_reg <= 1'b0;
      end else begin
         rd_d_reg <= rd_s & cs_s;
         wr_d_reg <= wr_s & cs_s;
         ack_d_reg <= ack_s;
      end
   end
   pic_ops_pkg::bus_req_s bus;
   logic rd_start;
   logic wr_end;
   logic ack_start;
   logic ack_end;
   assign bus.data = data_reg;
   assign bus.addr = addr_reg;
   assign bus.rd = rd_s & cs_s;
   assign bus.wr = wr_s & cs_s;
   assign rd_start = bus.rd & ~rd_d_reg;
   // commands take effect at the trailing edge of the write strobe
   assign wr_end = ~bus.wr & wr_d_reg;
   assign ack_start = ack_s & ~ack_d_reg;
   assign ack_end = ~ack_s & ack_d_reg;
   logic [7:0] cmd_reg;
   logic cmd_addr_reg;
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         cmd_reg <= 8'h00;
         cmd_addr_reg <= 1'b0;
      end else if (bus.wr) begin
         cmd_reg <= bus.data;
         cmd_addr_reg <= bus.addr;
      end
   end
   logic mask_wr;
   logic prio_wr;
   logic mode_wr;
   assign mask_wr = wr_end & cmd_addr_reg;
   assign prio_wr = wr_end & ~cmd_addr_reg & ~cmd_reg[`CMD_KIND_BIT] & ~cmd_reg[`CMD_MODE_BIT];
   assign mode_wr = wr_end & ~cmd_addr_reg & ~cmd_reg[`CMD_KIND_BIT]
      & cmd_reg[`CMD_MODE_BIT];
   logic rotate;
   logic level_sel;
   logic done;
   logic [2:0] level_code;
   assign rotate = cmd_reg[`PRIO_ROTATE_BIT];
   assign level_sel = cmd_reg[`PRIO_LEVEL_SEL_BIT];
   assign done = cmd_reg[`PRIO_DONE_BIT];
   assign level_code = cmd_reg[2:0];
   // registers
   logic [7:0] channel_mask_register;
   logic [7:0] pending_request_register;
   logic [7:0] in_service_register;
   logic [2:0] lowest_reg;
   logic special_mask_reg;
   logic rotate_auto_reg;
   logic query_reg;
   pic_ops_pkg::read_sel_e read_sel_reg;
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) channel_mask_register <= `MASK_RESET;
      else if (mask_wr) channel_mask_register <= cmd_reg;
   end
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) special_mask_reg <= 1'b0;
      else if (mode_wr && cmd_reg[`MODE_UNLOCK_BIT])
         special_mask_reg <= cmd_reg[`MODE_SPECIAL_BIT];
   end
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) read_sel_reg <= pic_ops_pkg::sel_request;
      else if (mode_wr && cmd_reg[`MODE_READ_BIT]) begin
         read_sel_reg <= cmd_reg[`MODE_SERVICE_SEL_BIT] ? pic_ops_pkg::sel_service
            : pic_ops_pkg::sel_request;
      end
   end
   // priority resolution
   logic [7:0] enabled_req;
   logic req_found;
   logic [2:0] req_level;
   logic svc_found;
   logic [2:0] svc_level;
   logic [7:0] svc_view;
   logic done_found;
   logic [2:0] done_level;
   assign enabled_req = pending_request_register & ~channel_mask_register;
   // under special masking, masked service bits neither inhibit nor get cleared by a non-specific or automatic end
   assign svc_view = special_mask_reg ? (in_service_register & ~channel_mask_register)
      : in_service_register;
   pic_ops_resolver #(.WIDTH(8)) u_req_res (
      .vec_in(enabled_req),
      .lowest_in(lowest_reg),
      .found_out(req_found),
      .level_out(req_level)
   );
   pic_ops_resolver #(.WIDTH(8)) u_svc_res (
      .vec_in(svc_view),
      .lowest_in(lowest_reg),
      .found_out(svc_found),
      .level_out(svc_level)
   );
   pic_ops_resolver #(.WIDTH(8)) u_done_res (
      .vec_in(svc_view),
      .lowest_in(lowest_reg),
      .found_out(done_found),
      .level_out(done_level)
   );
   // rank: 0 is highest priority under the current rotation
   function automatic logic [2:0] rank(input logic [2:0] lvl, input logic [2:0] low);
      rank = 3'(lvl - low - 3'h1);
   endfunction : rank
   logic int_next;
   always_comb begin
      int_next = 1'b0;
      if (req_found) begin
         if (special_mask_reg) int_next = 1'b1;
         else if (!svc_found || rank(req_level, lowest_reg) < rank(svc_level, lowest_reg))
            int_next = 1'b1;
      end
   end
   // acknowledge sequence
   logic [1:0] ack_count_reg;
   logic [2:0] ack_level_reg;
   logic ack_valid_reg;
   logic [1:0] ack_last;
   logic last_ack_end;
   assign ack_last = cpu16_mode_in ? `ACK_LAST_16BIT : `ACK_LAST_8BIT;
   assign last_ack_end = ack_end && (ack_count_reg == ack_last);
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) ack_count_reg <= 2'h0;
      else if (last_ack_end) ack_count_reg <= 2'h0;
      else if (ack_end) ack_count_reg <= 2'(ack_count_reg + 2'h1);
   end
   logic poll_read;
   assign poll_read = rd_start && query_reg;
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) query_reg <= 1'b0;
      else if (mode_wr) query_reg <= cmd_reg[`MODE_QUERY_BIT];
      else if (poll_read) query_reg <= 1'b0;
   end
   logic take_ack;
   assign take_ack = (ack_start && ack_count_reg == 2'h0 && req_found) || (poll_read && req_found);
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         ack_level_reg <= 3'h0;
         ack_valid_reg <= 1'b0;
      end else if (take_ack) begin
         ack_level_reg <= req_level;
         ack_valid_reg <= 1'b1;
      end
   end
   // request capture; frozen while a query waits for its read
   logic [7:0] req_prev_reg;
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) req_prev_reg <= 8'h00;
      else req_prev_reg <= req_sync;
   end
   logic freeze;
   assign freeze = query_reg && !poll_read;
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) pending_request_register <= 8'h00;
      else begin
         for (int i = 0; i < 8; i++) begin
            if (take_ack && req_level == 3'(i))
               pending_request_register[i] <= 1'b0;
            else if (!freeze && req_sync[i] && !req_prev_reg[i])
               pending_request_register[i] <= 1'b1;
            else if (!freeze && !req_sync[i])
               pending_request_register[i] <= 1'b0;
         end
      end
   end
   logic auto_done;
   assign auto_done = last_ack_end && auto_service_done_in;
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) in_service_register <= 8'h00;
      else begin
         for (int i = 0; i < 8; i++) begin
            if (take_ack && req_level == 3'(i))
               in_service_register[i] <= 1'b1;
            else if (prio_wr && done && level_sel && level_code == 3'(i))
               in_service_register[i] <= 1'b0;
            else if (prio_wr && done && !level_sel && done_found && done_level == 3'(i))
               in_service_register[i] <= 1'b0;
            else if (auto_done && done_found && done_level == 3'(i))
               in_service_register[i] <= 1'b0;
         end
      end
   end
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) rotate_auto_reg <= 1'b0;
      else if (prio_wr && !level_sel && !done) rotate_auto_reg <= rotate;
   end
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) lowest_reg <= `LOWEST_RESET;
      else if (prio_wr && rotate && level_sel) lowest_reg <= level_code;
      else if (prio_wr && rotate && done && !level_sel && done_found)
         lowest_reg <= done_level;
      else if (auto_done && rotate_auto_reg && done_found) lowest_reg <= done_level;
   end
   // interrupt output and read data
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) interrupt_out <= 1'b0;
      else interrupt_out <= int_next;
   end
   assign special_mask_out = special_mask_reg;
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         data_out <= 8'h00;
         data_oe_out <= 1'b0;
      end else begin
         data_oe_out <= bus.rd;
         if (rd_start) begin
            if (query_reg) begin
               data_out <= 8'h00;
               data_out[`POLL_VALID_BIT] <= req_found;
               data_out[2:0] <= req_level;
            end else if (bus.addr) data_out <= channel_mask_register;
            else if (read_sel_reg == pic_ops_pkg::sel_service) data_out <= in_service_register;
            else data_out <= pending_request_register;
         end else if (ack_start && ack_count_reg != 2'h0 && ack_valid_reg) begin
            // minimal vector: level number; base formatting lives elsewhere
            data_out <= {5'h00, ack_level_reg};
         end
      end
   end
endmodule : pic_ops_top

// file: pic_ops_top_monitor.sv
module pic_ops_monitor (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic chip_select_n_in,
   input wire logic read_n_in,
   input wire logic write_n_in,
   input wire logic addr_in,
   input wire logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic data_oe_out,
   input wire logic [7:0] request_inputs_in,
   input wire logic acknowledge_strobe_n_in,
   input wire logic interrupt_out,
   input wire logic special_mask_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   logic wr_q, rd_q, wr_a, poll_q;
   logic [7:0] wr_d, mask_m;
   logic [3:0] age;
   wire wr_done = wr_q && write_n_in;
   // shadow copies follow the pins, so they lead the synchronised design state
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         wr_a <= 1'b0;
         wr_d <= 8'h00;
         poll_q <= 1'b0;
         mask_m <= 8'h00;
         age <= 4'hF;
      end else begin
         wr_q <= !write_n_in && !chip_select_n_in;
         rd_q <= !read_n_in && !chip_select_n_in;
         if (!write_n_in && !chip_select_n_in) begin
            wr_d <= data_in;
            wr_a <= addr_in;
         end
         if (wr_done && wr_a) mask_m <= wr_d;
         if (wr_done && !wr_a && wr_d[4:3] == 2'b01) poll_q <= wr_d[2];
         else if (rd_q && read_n_in) poll_q <= 1'b0;
         age <= wr_done ? 4'h0 : (age == 4'hF ? age : age + 4'h1);
      end
   end
   sequence mode_wr_s;
      wr_done && !wr_a && wr_d[4:3] == 2'b01 && wr_d[6];
   endsequence
   sequence poll_rd_s;
      (poll_q && !addr_in && data_oe_out) [*3];
   endsequence
   chk_special_enter:
   assert property (mode_wr_s |-> ##[1:7] special_mask_out == wr_d[5])
      else $error("special mask state missed");
   chk_special_cause:
   assert property ($changed(special_mask_out) |-> age <= 4'h8)
      else $error("special mask changed without a write");
   chk_poll_format:
   assert property (poll_rd_s |-> data_out[6:3] == 4'h0 && (data_out[7] || data_out[2:0] == 3'h0))
      else $error("poll word malformed");
   chk_mask_readback:
   assert property ((addr_in && data_oe_out) [*3] |-> data_out == mask_m)
      else $error("mask read mismatch");
   chk_masked_quiet:
   assert property ((mask_m == 8'hFF) [*8] |=> !interrupt_out)
      else $error("interrupt with all inputs masked");
   chk_idle_quiet:
   assert property ((request_inputs_in == 8'h00) [*8] |=> !interrupt_out)
      else $error("interrupt without requests");
   chk_oe_release:
   assert property ((read_n_in && acknowledge_strobe_n_in) [*6] |=> !data_oe_out)
      else $error("bus driven without read");
   chk_reset_quiet:
   assert property ($fell(rst_in) |-> !interrupt_out [*3])
      else $error("interrupt right after reset");
endmodule : pic_ops_monitor

// file: pic_ops_host_model.sv
module pic_ops_host_model (
   input wire logic clock_in,
   input wire logic [7:0] rd_data_in,
   output logic cs_n_out,
   output logic rd_n_out,
   output logic wr_n_out,
   output logic addr_out,
   output logic [7:0] wr_data_out,
   output logic ack_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cs_n_out = 1'b1;
      rd_n_out = 1'b1;
      wr_n_out = 1'b1;
      addr_out = 1'b0;
      wr_data_out = 8'h00;
      ack_n_out = 1'b1;
   end
   task automatic wr(input logic a, input logic [7:0] d);
      @(posedge clock_in);
      cs_n_out <= 1'b0;
      wr_n_out <= 1'b0;
      addr_out <= a;
      wr_data_out <= d;
      repeat (6) @(posedge clock_in);
      cs_n_out <= 1'b1;
      wr_n_out <= 1'b1;
      @(posedge clock_in);
      // released bus shows inverted data so a late latch cannot pass
      wr_data_out <= ~d;
      repeat (8) @(posedge clock_in);
   endtask : wr
   task automatic rd(input logic a, output logic [7:0] q);
      @(posedge clock_in);
      cs_n_out <= 1'b0;
      rd_n_out <= 1'b0;
      addr_out <= a;
      repeat (8) @(posedge clock_in);
      q = rd_data_in;
      cs_n_out <= 1'b1;
      rd_n_out <= 1'b1;
      repeat (8) @(posedge clock_in);
   endtask : rd
   task automatic ack(input int n);
      repeat (n) begin
         @(posedge clock_in);
         ack_n_out <= 1'b0;
         repeat (6) @(posedge clock_in);
         ack_n_out <= 1'b1;
         repeat (8) @(posedge clock_in);
      end
   endtask : ack
endmodule : pic_ops_host_model

// file: priority_interrupt_operation_control_tb.sv
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
   $display("BAD %0t got %h expected %h", $time, got, exp); end end
module priority_interrupt_operation_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic cs_n, rd_n, wr_n, addr, ack_n, oe, intr, smask;
   logic auto_sd = 1'b0;
   logic cpu16 = 1'b1;
   logic [7:0] req = 8'h00;
   logic [7:0] wdata, rdata, q;
   int failures = 0;
   int n_compared = 0;
   initial begin
      forever #50 clock_in = ~clock_in;
   end
   pic_ops_top dut (
      .clock_in,
      .rst_in,
      .chip_select_n_in(cs_n),
      .read_n_in(rd_n),
      .write_n_in(wr_n),
      .addr_in(addr),
      .data_in(wdata),
      .data_out(rdata),
      .data_oe_out(oe),
      .request_inputs_in(req),
      .acknowledge_strobe_n_in(ack_n),
      .auto_service_done_in(auto_sd),
      .cpu16_mode_in(cpu16),
      .interrupt_out(intr),
      .special_mask_out(smask)
   );
   pic_ops_host_model host (
      .clock_in,
      .rd_data_in(rdata),
      .cs_n_out(cs_n),
      .rd_n_out(rd_n),
      .wr_n_out(wr_n),
      .addr_out(addr),
      .wr_data_out(wdata),
      .ack_n_out(ack_n)
   );
   task automatic tally_and_finish();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk_rd(input logic a, input logic [7:0] e);
      host.rd(a, q);
      `CHECK(q, e)
   endtask : chk_rd
   // request pins pass a synchroniser, so allow settling time
   task automatic rq(input logic [7:0] v);
      @(posedge clock_in);
      req <= v;
      repeat (10) @(posedge clock_in);
   endtask : rq
   initial begin
      #500000;
      failures++;
      tally_and_finish();
   end
   initial begin
      repeat (2) @(posedge clock_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge clock_in);
      chk_rd(1'b0, 8'h00);
      chk_rd(1'b1, 8'h00);
      host.wr(1'b1, 8'h5A);
      chk_rd(1'b1, 8'h5A);
      host.wr(1'b1, 8'hFF);
      rq(8'h08);
      chk_rd(1'b0, 8'h08);
      `CHECK(intr, 1'b0)
      host.wr(1'b1, 8'h00);
      `CHECK(intr, 1'b1)
      rq(8'h28);
      host.ack(2);
      host.wr(1'b0, 8'h0B);
      chk_rd(1'b0, 8'h08);
      host.wr(1'b0, 8'h0A);
      chk_rd(1'b0, 8'h20);
      `CHECK(intr, 1'b0)
      rq(8'h2A);
      `CHECK(intr, 1'b1)
      host.ack(2);
      host.wr(1'b0, 8'h0B);
      chk_rd(1'b0, 8'h0A);
      host.wr(1'b0, 8'h20);
      chk_rd(1'b0, 8'h08);
      host.wr(1'b0, 8'h63);
      chk_rd(1'b0, 8'h00);
      rq(8'h21);
      host.wr(1'b0, 8'hC4);
      host.wr(1'b0, 8'h0C);
      chk_rd(1'b0, 8'h85);
      host.wr(1'b0, 8'h0B);
      chk_rd(1'b0, 8'h20);
      host.wr(1'b0, 8'hE5);
      host.wr(1'b0, 8'h0E);
      chk_rd(1'b0, 8'h80);
      host.wr(1'b0, 8'h0B);
      chk_rd(1'b0, 8'h01);
      host.wr(1'b0, 8'hA0);
      chk_rd(1'b0, 8'h00);
      rq(8'h25);
      host.ack(2);
      chk_rd(1'b0, 8'h04);
      host.wr(1'b0, 8'h68);
      `CHECK(smask, 1'b1)
      host.wr(1'b0, 8'h28);
      `CHECK(smask, 1'b1)
      host.wr(1'b1, 8'h04);
      rq(8'h65);
      `CHECK(intr, 1'b1)
      host.wr(1'b0, 8'h20);
      chk_rd(1'b0, 8'h04);
      host.wr(1'b0, 8'h48);
      `CHECK(smask, 1'b0)
      host.wr(1'b0, 8'h20);
      chk_rd(1'b0, 8'h00);
      host.wr(1'b1, 8'h00);
      auto_sd <= 1'b1;
      cpu16 <= 1'b0;
      host.wr(1'b0, 8'h80);
      host.ack(3);
      chk_rd(1'b0, 8'h00);
      rq(8'hE7);
      host.wr(1'b0, 8'h0C);
      chk_rd(1'b0, 8'h87);
      tally_and_finish();
   end
endmodule : priority_interrupt_operation_control_tb
bind pic_ops_top pic_ops_monitor mon (
   .clock_in,
   .rst_in,
   .chip_select_n_in,
   .read_n_in,
   .write_n_in,
   .addr_in,
   .data_in,
   .data_out,
   .data_oe_out,
   .request_inputs_in,
   .acknowledge_strobe_n_in,
   .interrupt_out,
   .special_mask_out
);
